/* File: logic/dtip_top.sv */
// dual target interrupt router with cpu and coprocessor decoders
//
// Summary of operation
// - route bit one sends channel to coprocessor
// - coprocessor choice uses channel priority level
// - coprocessor flags raise cpu vector base+2*channel
// - flag interrupts share one configured priority
// - ties go to highest vector address
// - separate decoders for cpu and coprocessor
// - coprocessor decoder ignores running thread level
// - coprocessor request carries priority msb tag
// - levels four to seven preempt threads below
// - cpu vector given only on cpu request
// - vector fetch returns highest request pending then
// - nothing pending at fetch gives spurious vector
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module dtip_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // interrupt sources and coprocessor flag setting
  input wire logic [dtip_pkg::NCH-1:0] irq_req_in,
  input wire logic [dtip_pkg::NCH-1:0] cop_flag_set_in,
  // cpu side
  input wire logic [dtip_pkg::PRIO_W-1:0] cpu_level_in,
  input wire logic cpu_vec_req_in,
  output logic cpu_irq_out,
  output logic cpu_vec_valid_out,
  output logic [dtip_pkg::VEC_W-1:0] cpu_vec_out,
  // coprocessor request port
  output logic cop_req_out,
  output logic [dtip_pkg::IDX_W-1:0] cop_chan_out,
  output logic cop_tag_out,
  // axi4-lite write address and data
  input wire logic [dtip_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [dtip_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------
  // configuration and state
  // ----------------------------------------------------------------
  logic [dtip_pkg::NCH-1:0] route; // coprocessor_route_select per channel
  logic [dtip_pkg::NCH-1:0][dtip_pkg::PRIO_W-1:0] prio; // channel_priority_level
  logic [dtip_pkg::PRIO_W-1:0] shared_prio; // coprocessor_shared_priority
  logic irq_enable; // coprocessor_irq_enable
  logic [dtip_pkg::VEC_W-1:0] src_vec_base; // vector table of source channels
  logic [dtip_pkg::VEC_W-1:0] flag_vec_base; // vector table of flag interrupts
  logic [dtip_pkg::VEC_W-1:0] spur_vec; // fallback vector
  logic [dtip_pkg::NCH-1:0] flags; // set by set_channel_flag_instruction
  logic [dtip_pkg::ADDR_W-1:0] aw_addr; // captured write address
  logic [31:0] w_data; // captured write data
  logic [3:0] w_strb; // captured byte enables
  logic aw_got; // write address held
  logic w_got; // write data held
  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire do_write = aw_got && w_got && !s_axi_bvalid; // one write per response
  wire wr_is_cfg = aw_addr <= dtip_pkg::OFS_CFG_LAST;
  wire [dtip_pkg::IDX_W-1:0] wr_chan = aw_addr[dtip_pkg::WORD_LSB +: dtip_pkg::IDX_W];
  wire wr_mapped = wr_is_cfg || (aw_addr == dtip_pkg::OFS_SHARED_PRIO)
    || (aw_addr == dtip_pkg::OFS_CTRL) || (aw_addr == dtip_pkg::OFS_SRC_VEC_BASE)
    || (aw_addr == dtip_pkg::OFS_FLAG_VEC_BASE) || (aw_addr == dtip_pkg::OFS_SPUR_VEC)
    || (aw_addr == dtip_pkg::OFS_FLAGS) || (aw_addr == dtip_pkg::OFS_STATUS)
    || (aw_addr == dtip_pkg::OFS_LAST_VEC);
  wire wr_lo = do_write && w_strb[0]; // byte lane 0 enabled
  wire wr_hi = do_write && w_strb[1]; // byte lane 1 enabled
  wire [dtip_pkg::NCH-1:0] flag_clr = (wr_lo && aw_addr == dtip_pkg::OFS_FLAGS)
    ? w_data[dtip_pkg::NCH-1:0] : '0;
  // a flag set in the cycle it is cleared survives
  wire [dtip_pkg::NCH-1:0] next_flags = (flags & ~flag_clr) | cop_flag_set_in;
  // ----------------------------------------------------------------
  // candidate sets for both targets
  // ----------------------------------------------------------------
  // a source is pending only while its line is high; level 0 is off
  logic [dtip_pkg::NCH-1:0] prio_nz; // level above zero per channel
  logic [dtip_pkg::NCH-1:0] cpu_src_act; // sources for the cpu
  logic [dtip_pkg::NCH-1:0] cop_src_act; // sources for the coprocessor
  logic [dtip_pkg::NCH-1:0] flag_act; // flag interrupts for the cpu
  logic [dtip_pkg::NCH-1:0][dtip_pkg::PRIO_W-1:0] flag_lvl; // shared level each
  genvar g;
  generate
    for (g = 0; g < dtip_pkg::NCH; g++)
    begin : g_chan
      assign prio_nz[g] = prio[g] != '0;
      assign cpu_src_act[g] = irq_req_in[g] && !route[g] && prio_nz[g];
      assign cop_src_act[g] = irq_req_in[g] && route[g] && prio_nz[g];
      // flag needs global enable and its own route bit
      assign flag_act[g] = flags[g] && route[g] && irq_enable && (shared_prio != '0);
      assign flag_lvl[g] = shared_prio;
    end
  endgenerate
  // ----------------------------------------------------------------
  // decoders, one per target
  // ----------------------------------------------------------------
  logic cpu_valid; // cpu has a winner
  logic [dtip_pkg::CPU_IW-1:0] cpu_idx; // winner: sources low, flags high
  logic [dtip_pkg::PRIO_W-1:0] cpu_lvl; // winner level
  logic cop_valid; // coprocessor has a winner
  logic [dtip_pkg::IDX_W-1:0] cop_idx; // coprocessor winner channel
  logic [dtip_pkg::PRIO_W-1:0] cop_lvl; // coprocessor winner level
  // flags sit above the sources so an equal level goes to a flag
  dtip_prio_dec #(.N(dtip_pkg::CPU_N), .IW(dtip_pkg::CPU_IW)) u_cpu_dec (
    .act_in({flag_act, cpu_src_act}),
    .lvl_in({flag_lvl, prio}),
    .valid_out(cpu_valid),
    .idx_out(cpu_idx),
    .lvl_out(cpu_lvl)
  );
  // no thread level input here: preemption is left to the coprocessor
  dtip_prio_dec #(.N(dtip_pkg::NCH), .IW(dtip_pkg::IDX_W)) u_cop_dec (
    .act_in(cop_src_act),
    .lvl_in(prio),
    .valid_out(cop_valid),
    .idx_out(cop_idx),
    .lvl_out(cop_lvl)
  );
  // ----------------------------------------------------------------
  // vector and tag formation
  // ----------------------------------------------------------------
  wire cpu_is_flag = cpu_idx[dtip_pkg::IDX_W];
  wire [dtip_pkg::IDX_W-1:0] cpu_chan = cpu_idx[dtip_pkg::IDX_W-1:0];
  wire [dtip_pkg::VEC_W-1:0] cpu_base = cpu_is_flag ? flag_vec_base : src_vec_base;
  // vector = base + 2 * channel
  wire [dtip_pkg::VEC_W-1:0] cpu_vec = dtip_pkg::VEC_W'(cpu_base
    + {cpu_chan, 1'b0});
  // vector chosen at the fetch cycle, spurious when nothing remains
  wire [dtip_pkg::VEC_W-1:0] next_vec = cpu_valid ? cpu_vec : spur_vec;
  wire cop_tag = cop_lvl[dtip_pkg::PRIO_MSB]; // levels 4..7 give one
  // ----------------------------------------------------------------
  // cpu vector port
  // ----------------------------------------------------------------
  // the vector is latched only when the cpu asks, never earlier, so a
  // later higher request still wins up to that cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cpu_vec_valid_out <= 1'b0;
      cpu_vec_out <= '0;
      cpu_irq_out <= 1'b0;
    end
    else
    begin
      cpu_vec_valid_out <= cpu_vec_req_in;
      if (cpu_vec_req_in)
        cpu_vec_out <= next_vec;
      cpu_irq_out <= cpu_valid && (cpu_lvl > cpu_level_in);
    end
  end
  // ----------------------------------------------------------------
  // coprocessor request port
  // ----------------------------------------------------------------
  // request follows the winner each cycle; the coprocessor reads the tag
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cop_req_out <= 1'b0;
      cop_chan_out <= '0;
      cop_tag_out <= 1'b0;
    end
    else
    begin
      cop_req_out <= cop_valid;
      cop_chan_out <= cop_idx;
      cop_tag_out <= cop_tag;
    end
  end
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      route <= '0;
      prio <= {dtip_pkg::NCH{dtip_pkg::RST_PRIO}};
      shared_prio <= dtip_pkg::RST_PRIO;
      irq_enable <= 1'b0;
      flags <= '0;
    end
    else
    begin
      flags <= next_flags;
      if (wr_lo && wr_is_cfg)
      begin
        route[wr_chan] <= w_data[dtip_pkg::ROUTE_BIT];
        prio[wr_chan] <= w_data[dtip_pkg::PRIO_MSB:0];
      end
      if (wr_lo && aw_addr == dtip_pkg::OFS_SHARED_PRIO)
        shared_prio <= w_data[dtip_pkg::PRIO_MSB:0];
      if (wr_lo && aw_addr == dtip_pkg::OFS_CTRL)
        irq_enable <= w_data[dtip_pkg::IRQ_EN_BIT];
    end
  end
  // vector registers take two byte lanes each
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      src_vec_base <= dtip_pkg::RST_SRC_VEC_BASE;
      flag_vec_base <= dtip_pkg::RST_FLAG_VEC_BASE;
      spur_vec <= dtip_pkg::RST_SPUR_VEC;
    end
    else
    begin
      if (wr_lo && aw_addr == dtip_pkg::OFS_SRC_VEC_BASE)
        src_vec_base[7:0] <= w_data[7:0];
      if (wr_hi && aw_addr == dtip_pkg::OFS_SRC_VEC_BASE)
        src_vec_base[15:8] <= w_data[15:8];
      if (wr_lo && aw_addr == dtip_pkg::OFS_FLAG_VEC_BASE)
        flag_vec_base[7:0] <= w_data[7:0];
      if (wr_hi && aw_addr == dtip_pkg::OFS_FLAG_VEC_BASE)
        flag_vec_base[15:8] <= w_data[15:8];
      if (wr_lo && aw_addr == dtip_pkg::OFS_SPUR_VEC)
        spur_vec[7:0] <= w_data[7:0];
      if (wr_hi && aw_addr == dtip_pkg::OFS_SPUR_VEC)
        spur_vec[15:8] <= w_data[15:8];
    end
  end
  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are taken in either order; ready drops until the
  // response is accepted, so only one write is ever in flight
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dtip_pkg::RESP_OKAY;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_got <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_got <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? dtip_pkg::RESP_OKAY : dtip_pkg::RESP_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire rd_is_cfg = s_axi_araddr <= dtip_pkg::OFS_CFG_LAST;
  wire [dtip_pkg::IDX_W-1:0] rd_chan = s_axi_araddr[dtip_pkg::WORD_LSB +: dtip_pkg::IDX_W];
  wire [31:0] rd_cfg = 32'({route[rd_chan], 4'h0, prio[rd_chan]});
  wire [31:0] rd_status = 32'({flags, irq_req_in}); // status: flags over lines
  wire rd_mapped = rd_is_cfg || (s_axi_araddr == dtip_pkg::OFS_SHARED_PRIO)
    || (s_axi_araddr == dtip_pkg::OFS_CTRL) || (s_axi_araddr == dtip_pkg::OFS_SRC_VEC_BASE)
    || (s_axi_araddr == dtip_pkg::OFS_FLAG_VEC_BASE)
    || (s_axi_araddr == dtip_pkg::OFS_SPUR_VEC) || (s_axi_araddr == dtip_pkg::OFS_FLAGS)
    || (s_axi_araddr == dtip_pkg::OFS_STATUS) || (s_axi_araddr == dtip_pkg::OFS_LAST_VEC);
  wire [31:0] rd_data =
    rd_is_cfg ? rd_cfg :
    (s_axi_araddr == dtip_pkg::OFS_SHARED_PRIO) ? 32'(shared_prio) :
    (s_axi_araddr == dtip_pkg::OFS_CTRL) ? 32'(irq_enable) :
    (s_axi_araddr == dtip_pkg::OFS_SRC_VEC_BASE) ? 32'(src_vec_base) :
    (s_axi_araddr == dtip_pkg::OFS_FLAG_VEC_BASE) ? 32'(flag_vec_base) :
    (s_axi_araddr == dtip_pkg::OFS_SPUR_VEC) ? 32'(spur_vec) :
    (s_axi_araddr == dtip_pkg::OFS_FLAGS) ? 32'(flags) :
    (s_axi_araddr == dtip_pkg::OFS_STATUS) ? rd_status :
    (s_axi_araddr == dtip_pkg::OFS_LAST_VEC) ? 32'(cpu_vec_out) : 32'h0000_0000;
  // data are captured with the address, so rvalid is one cycle later
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= dtip_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_mapped ? dtip_pkg::RESP_OKAY : dtip_pkg::RESP_DECERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence seq_fetch_empty;
    cpu_vec_req_in && !cpu_valid;
  endsequence
  sequence seq_vec_shown;
    ##1 cpu_vec_valid_out;
  endsequence
  AST_VEC_ON_REQ_ONLY: assert property (@(posedge clk_in) disable iff (rst_in)
    cpu_vec_valid_out |-> $past(cpu_vec_req_in))
    else $error("vector shown without cpu request");
  AST_SPURIOUS_VEC: assert property (@(posedge clk_in) disable iff (rst_in)
    seq_fetch_empty |-> seq_vec_shown ##0 (cpu_vec_out == spur_vec))
    else $error("empty fetch did not give spurious vector");
  AST_FETCH_WINNER: assert property (@(posedge clk_in) disable iff (rst_in)
    (cpu_vec_req_in && cpu_valid && !cpu_is_flag) |=>
    (cpu_vec_out == src_vec_base + {$past(cpu_idx[dtip_pkg::IDX_W-1:0]), 1'b0}))
    else $error("fetched vector is not the pending winner");
  AST_ROUTED_NOT_CPU: assert property (@(posedge clk_in) disable iff (rst_in)
    (cpu_src_act & route) == '0 && (cop_src_act & ~route) == '0)
    else $error("channel reached the wrong target");
  AST_COP_FOLLOWS: assert property (@(posedge clk_in) disable iff (rst_in)
    cop_valid |=> cop_req_out && route[cop_chan_out] ##0
    (cop_chan_out == $past(cop_idx)))
    else $error("coprocessor request missing or wrong channel");
  AST_COP_TAG: assert property (@(posedge clk_in) disable iff (rst_in)
    cop_valid |=> cop_tag_out == ($past(cop_lvl) > 3'h3))
    else $error("coprocessor tag does not match level msb");
  AST_FLAG_GATED: assert property (@(posedge clk_in) disable iff (rst_in)
    (!irq_enable || flags == '0) |-> flag_act == '0)
    else $error("flag interrupt without enable or flag");
  AST_FLAG_SET_WINS: assert property (@(posedge clk_in) disable iff (rst_in)
    (cop_flag_set_in != '0) |=> (flags & $past(cop_flag_set_in)) == $past(cop_flag_set_in))
    else $error("flag set was lost");
  AST_FLAG_LEVEL: assert property (@(posedge clk_in) disable iff (rst_in)
    (cpu_valid && cpu_is_flag) |-> cpu_lvl == shared_prio)
    else $error("flag winner not at shared level");
  AST_COP_NO_THREAD: assert property (@(posedge clk_in) disable iff (rst_in)
    (cop_src_act != '0) |-> ##1 cop_req_out [*1])
    else $error("coprocessor request held back");
endmodule
`default_nettype wire

/* File: logic/dtip_pkg.sv */
// constants shared by the dual target interrupt priority block
`default_nettype none
package dtip_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH = 8; // request channels
  localparam int IDX_W = 3; // channel index width
  localparam int PRIO_W = 3; // priority level width
  localparam int VEC_W = 16; // vector address width
  localparam int ADDR_W = 8; // register bus address width
  localparam int CPU_N = 2 * NCH; // cpu candidates: sources then flags
  localparam int CPU_IW = IDX_W + 1; // cpu candidate index width
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CFG_FIRST = 8'h00; // channel n at 4*n
  localparam logic [ADDR_W-1:0] OFS_CFG_LAST = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_SHARED_PRIO = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_SRC_VEC_BASE = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_FLAG_VEC_BASE = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_SPUR_VEC = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_LAST_VEC = 8'h3c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ROUTE_BIT = 7; // coprocessor_route_select in config
  localparam int PRIO_MSB = 2; // channel_priority_level [2:0]
  localparam int IRQ_EN_BIT = 0; // coprocessor_irq_enable in control
  localparam int STAT_FLAGS_LSB = 8; // status: flags above source lines
  localparam int WORD_LSB = 2; // word select inside byte address
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PRIO_W-1:0] RST_PRIO = 3'h1;
  localparam logic [VEC_W-1:0] RST_SRC_VEC_BASE = 16'h0000;
  localparam logic [VEC_W-1:0] RST_FLAG_VEC_BASE = 16'h0040;
  localparam logic [VEC_W-1:0] RST_SPUR_VEC = 16'h00fe;
  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage
`default_nettype wire

/* File: logic/dtip_prio_dec.sv */
// one priority decoder: highest level wins, ties go to the highest index
`timescale 1ns/1ns
`default_nettype none
module dtip_prio_dec #(
  parameter int N = 8,
  parameter int IW = 3
) (
  // candidates
  input wire logic [N-1:0] act_in,
  input wire logic [N-1:0][dtip_pkg::PRIO_W-1:0] lvl_in,
  // winner
  output logic valid_out,
  output logic [IW-1:0] idx_out,
  output logic [dtip_pkg::PRIO_W-1:0] lvl_out
);
  // ----------------------------------------------------------------
  // linear scan upward
  // ----------------------------------------------------------------
  // using >= lets a later index take an equal level, so the highest
  // index (highest vector address) wins a tie
  always_comb
  begin
    valid_out = 1'b0;
    idx_out = '0;
    lvl_out = '0;
    for (int i = 0; i < N; i++)
    begin
      if (act_in[i] && (!valid_out || lvl_in[i] >= lvl_out))
      begin
        valid_out = 1'b1;
        idx_out = IW'(i);
        lvl_out = lvl_in[i];
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/dtip_far_model.sv */
// behavioural cpu vector fetch and coprocessor request port partner
`timescale 1ns/1ns
`default_nettype none
module dtip_far_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // cpu fetch side
  input wire logic fetch_in,
  input wire logic cpu_vec_valid_in,
  input wire logic [15:0] cpu_vec_in,
  output logic cpu_vec_req_out,
  output logic [15:0] vec_out,
  // coprocessor side
  input wire logic cop_req_in,
  input wire logic cop_tag_in,
  input wire logic [2:0] thread_level_in,
  output logic preempt_out
);
  // ----------------------------------------------------------------
  // fetch: one request pulse per fetch, vector kept when it comes
  // ----------------------------------------------------------------
  assign cpu_vec_req_out = fetch_in;
  // hold last vector so the bench may look at it late
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      vec_out <= 16'h0000;
    else if (cpu_vec_valid_in)
      vec_out <= cpu_vec_in;
  end
  // only a high tag may break into a running low thread
  assign preempt_out = cop_req_in & cop_tag_in & (thread_level_in != 3'h0)
    & (thread_level_in < 3'h4);
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the dual target interrupt router
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0, rst_in = 1'b1, fetch = 1'b0;
  logic [7:0] irq = 8'h00, flag_set = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cpu_irq, vvalid, vreq, creq, ctag, pre;
  logic [1:0] bresp, rresp;
  logic [15:0] cvec, pvec;
  logic [2:0] cchan;
  logic [2:0] thread = 3'h2; // low running coprocessor thread
  logic [2:0] cpu_level = 3'h0; // level of the code the cpu is running
  int err_count = 0, num_checks = 0, cyc = 0;
  // ----------------------------------------------------------------
  // instances and clock
  // ----------------------------------------------------------------
  dtip_top dut (.clk_in(clk_in), .rst_in(rst_in), .irq_req_in(irq), .cop_flag_set_in(flag_set),
    .cpu_level_in(cpu_level), .cpu_vec_req_in(vreq), .cpu_irq_out(cpu_irq),
    .cpu_vec_valid_out(vvalid), .cpu_vec_out(cvec), .cop_req_out(creq), .cop_chan_out(cchan),
    .cop_tag_out(ctag), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  dtip_far_model far (.clk_in(clk_in), .rst_in(rst_in), .fetch_in(fetch),
    .cpu_vec_valid_in(vvalid), .cpu_vec_in(cvec), .cpu_vec_req_out(vreq), .vec_out(pvec),
    .cop_req_in(creq), .cop_tag_in(ctag), .thread_level_in(thread), .preempt_out(pre));
  initial forever #5 clk_in = ~clk_in;
  // cut a hang short; the whole run needs well under this
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
    @(posedge clk_in);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    chk("rresp", er, rresp);
    chk("rdata", ed, rdata);
    @(posedge clk_in);
  endtask
  // new source levels land on the same edge as the fetch request
  task automatic vfetch(input logic [7:0] lines, input logic [15:0] ev);
    irq <= lines;
    fetch <= 1'b1;
    @(posedge clk_in);
    fetch <= 1'b0;
    @(posedge clk_in);
    chk("vec valid", 32'h1, vvalid);
    @(posedge clk_in);
    chk("vec valid", 32'h0, vvalid);
    chk("cpu vector", ev, pvec);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    axr(8'h20, 32'h1, 2'b00);
    axr(8'h2c, 32'h40, 2'b00);
    axr(8'h30, 32'hfe, 2'b00);
    axr(8'h40, 32'h0, 2'b11);
    axw(8'h40, 32'h5, 2'b11);
  endtask
  task automatic t_cop;
    axw(8'h08, 32'h86, 2'b00);
    axw(8'h14, 32'h83, 2'b00);
    vfetch(8'h24, 16'h00fe);
    chk("cop chan", 32'h2, cchan);
    chk("cop tag", 32'h1, ctag);
    chk("preempt", 32'h1, pre);
    irq <= 8'h20;
    repeat (2) @(posedge clk_in);
    chk("cop chan", 32'h5, cchan);
    chk("cop req", 32'h1, creq);
    chk("preempt", 32'h0, pre);
  endtask
  task automatic t_vec;
    axw(8'h04, 32'h02, 2'b00);
    axw(8'h0c, 32'h04, 2'b00);
    vfetch(8'h02, 16'h0002);
    chk("cop req", 32'h0, creq);
    vfetch(8'h0a, 16'h0006);
    chk("cpu irq", 32'h1, cpu_irq);
    // a running level equal to the winner's holds the cpu line off
    cpu_level <= 3'h4;
    repeat (2) @(posedge clk_in);
    chk("cpu irq", 32'h0, cpu_irq);
    cpu_level <= 3'h0;
    vfetch(8'h00, 16'h00fe);
    chk("cpu irq", 32'h0, cpu_irq);
  endtask
  task automatic t_flag;
    axw(8'h24, 32'h1, 2'b00);
    flag_set <= 8'h24;
    @(posedge clk_in);
    flag_set <= 8'h00;
    axr(8'h38, 32'h2400, 2'b00);
    axw(8'h20, 32'h7, 2'b00);
    vfetch(8'h08, 16'h004a);
    axw(8'h20, 32'h2, 2'b00);
    vfetch(8'h08, 16'h0006);
    axw(8'h34, 32'hff, 2'b00);
    vfetch(8'h00, 16'h00fe);
  endtask
  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_regs();
    t_cop();
    t_vec();
    t_flag();
    results();
  end
endmodule
`default_nettype wire
